// >>> design/swa_slave.sv
//
// Purpose: serial slave giving an outside master 16-bit word access
// Assumes: link pins are asynchronous; system clock at least 8x link clock
// Notes:   reply line is always driven, never released
//
`timescale 1ns/10ps
module swa_slave (
    input  wire logic I_SYS_CLK,
    input  wire logic I_RST_B,
    input  wire logic I_CPU_RUN,
    input  wire logic I_CHIP_SELECT_N,
    input  wire logic I_SPI_SCLK,
    input  wire logic I_SPI_MOSI,
    output logic      O_SPI_MISO
);
    import swa_pkg::*;

    logic [1:0]  rst_sync;
    logic        rst_n;
    swa_slave_s  q;
    swa_slave_s  next_q;
    logic        rise;
    swa_mem_if   mem ();

    // true on the last bit of a field
    function automatic logic field_done(input logic [3:0] c, input logic [3:0] last);
        return c == last;
    endfunction

    // ************************************************************
    // reset release
    // ************************************************************
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // rising link clock seen after the synchronisers
    assign rise = q.sclk_s1 & ~q.sclk_prev;

    // ************************************************************
    // transaction engine
    // ************************************************************
    always_comb begin
        next_q           = q;
        mem.we           = 1'b0;
        mem.addr         = q.addr[MEM_AW-1:0];
        mem.wdata        = WORD_RST;
        next_q.cs_s0     = I_CHIP_SELECT_N;
        next_q.cs_s1     = q.cs_s0;
        next_q.sclk_s0   = I_SPI_SCLK;
        next_q.sclk_s1   = q.sclk_s0;
        next_q.mosi_s0   = I_SPI_MOSI;
        next_q.mosi_s1   = q.mosi_s0;
        next_q.sclk_prev = q.sclk_s1;
        // no gating by I_CPU_RUN: serviced either way
        if (q.cs_s1) begin
            // deselected: restart, drive run-state level
            next_q.fsm    = ST_IDLE;
            next_q.cnt    = 4'h0;
            next_q.out_sr = WORD_RST;
            next_q.miso   = ~I_CPU_RUN;
        end else if (rise) begin
            // msb first in and out
            next_q.cnt    = q.cnt + 4'h1;
            next_q.in_sr  = {q.in_sr[14:0], q.mosi_s1};
            next_q.out_sr = {q.out_sr[14:0], 1'b0};
            next_q.miso   = q.out_sr[15];
            case (q.fsm)
                ST_IDLE, ST_CMD: begin
                    next_q.fsm = ST_CMD;
                    if (field_done(q.cnt, CNT_CMD_LAST)) begin
                        next_q.cmd = next_q.in_sr[7:0];
                        next_q.cnt = 4'h0;
                        // only the two commands are answered
                        if (next_q.in_sr[7:0] == CMD_WRITE || next_q.in_sr[7:0] == CMD_READ) begin
                            next_q.fsm = ST_ADDR;
                        end else begin
                            next_q.fsm = ST_SKIP;
                        end
                    end
                end
                ST_ADDR: begin
                    if (field_done(q.cnt, CNT_WORD_LAST)) begin
                        next_q.addr = next_q.in_sr;
                        if (q.cmd == CMD_WRITE) begin
                            next_q.fsm = ST_WDATA;
                        end else begin
                            // check word goes out first
                            next_q.fsm    = ST_RCHK;
                            next_q.out_sr = {q.cmd, next_q.in_sr[15:8]};
                            // its top bit goes out on the next rise, after the address
                        end
                    end
                end
                ST_WDATA: begin
                    if (field_done(q.cnt, CNT_WORD_LAST)) begin
                        // store word, stay for auto-increment
                        mem.we      = 1'b1;
                        mem.wdata   = next_q.in_sr;
                        next_q.addr = q.addr + 16'h0001;
                    end
                end
                ST_RCHK, ST_RDATA: begin
                    if (field_done(q.cnt, CNT_WORD_LAST)) begin
                        // load addressed word, no further check word
                        next_q.fsm    = ST_RDATA;
                        next_q.out_sr = mem.rdata;
                        // last bit of the previous word stays out until the next rise
                        next_q.addr   = q.addr + 16'h0001;
                    end
                end
                default: begin
                    next_q.fsm = ST_SKIP;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= SLAVE_RST;
        end else begin
            q <= next_q;
        end
    end

    // reply line always driven
    assign O_SPI_MISO = q.miso;

    // ************************************************************
    // word store
    // ************************************************************
    swa_mem u_mem (
        .i_clk   (I_SYS_CLK),
        .i_rst_n (rst_n),
        .mem     (mem.store)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!rst_n);

    idle_miso_level_a: assert property (
        q.cs_s1 |=> (q.miso == ~$past(I_CPU_RUN)))
        else $error("idle reply level does not follow processor state");

    deselect_restart_a: assert property (
        q.cs_s1 |=> (q.fsm == ST_IDLE) && (q.cnt == 4'h0))
        else $error("deselect did not restart the transaction");

    cmd_length_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_CMD && q.cnt == CNT_CMD_LAST)
        |=> (q.fsm == ST_ADDR || q.fsm == ST_SKIP) && q.cnt == 4'h0)
        else $error("command field not eight bits");

    mosi_capture_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_ADDR) |=> (q.in_sr[0] == $past(q.mosi_s1)))
        else $error("master data not taken on rising clock");

    check_word_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_ADDR && q.cnt == CNT_WORD_LAST && q.cmd == CMD_READ)
        |=> (q.out_sr == {CMD_READ, q.addr[15:8]}) && q.miso == 1'b0 && q.fsm == ST_RCHK)
        else $error("check word not loaded after read address");

    write_incr_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_WDATA && q.cnt == CNT_WORD_LAST)
        |=> (q.addr == $past(q.addr) + 16'h0001) && q.fsm == ST_WDATA)
        else $error("write address did not advance by one");

    write_strobe_a: assert property (
        mem.we |-> (rise && q.fsm == ST_WDATA && q.cnt == CNT_WORD_LAST))
        else $error("store written outside a completed data word");

    read_repeat_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_RDATA && q.cnt == CNT_WORD_LAST)
        |=> (q.fsm == ST_RDATA) && (q.out_sr == $past(mem.rdata)) && q.addr == $past(q.addr) + 16'h0001)
        else $error("repeated read did not return next word");

    miso_timing_a: assert property (
        (!q.cs_s1 && !$past(q.cs_s1) && $changed(q.miso)) |-> $past(rise))
        else $error("reply bit changed away from a rising clock");

    // ************************************************************
    // shifter and address counter checks
    // ************************************************************
    // every reply bit comes from the top of the shifter
    shift_msb_first_a: assert property (
        (rise && !q.cs_s1) |=> (q.miso == $past(q.out_sr[15])))
        else $error("reply bit not taken from top of shifter");

    capture_on_rise_a: assert property (
        !(rise && !q.cs_s1) |=> $stable(q.in_sr))
        else $error("master data taken without a rising clock");

    check_bit_order_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_RCHK && q.cnt == 4'h7) |=> (q.miso == q.cmd[0]))
        else $error("check word bit shown in the wrong clock");

    read_load_a: assert property (
        (rise && !q.cs_s1 && q.fsm == ST_RCHK && q.cnt == CNT_WORD_LAST)
        |=> (q.fsm == ST_RDATA) && (q.out_sr == $past(mem.rdata)) && q.addr == $past(q.addr) + 16'h0001)
        else $error("data word did not follow the check word");

    write_reply_low_a: assert property (
        (!q.cs_s1 && q.fsm == ST_WDATA) |-> (q.miso == 1'b0))
        else $error("reply line not low during a write");

    unknown_cmd_quiet_a: assert property (
        (q.fsm == ST_SKIP) |-> !mem.we && (q.miso == 1'b0))
        else $error("unknown command touched store or reply");

    addr_hold_a: assert property (
        !(rise && !q.cs_s1 && q.cnt == CNT_WORD_LAST) |=> $stable(q.addr))
        else $error("word address moved inside a word");
endmodule // swa_slave

// >>> design/swa_pkg.sv
//
// Purpose: shared constants and types for the serial word access slave
// Assumes: 25 MHz system clock samples the serial link pins
// Notes:   internal memory window is a small on-chip word store
package swa_pkg;

    // ************************************************************
    // protocol constants
    // ************************************************************
    localparam int          WORD_W     = 16;
    localparam int          MEM_AW     = 8;
    localparam int          MEM_DEPTH  = 256;
    localparam logic [7:0]  CMD_WRITE  = 8'h02;
    localparam logic [7:0]  CMD_READ   = 8'h03;
    localparam logic [3:0]  CNT_CMD_LAST  = 4'h7;
    localparam logic [3:0]  CNT_WORD_LAST = 4'hF;
    localparam logic [15:0] ADDR_RST   = 16'h0000;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_CMD   = 7'h02,
        ST_ADDR  = 7'h04,
        ST_WDATA = 7'h08,
        ST_RCHK  = 7'h10,
        ST_RDATA = 7'h20,
        ST_SKIP  = 7'h40
    } swa_state_e;

    typedef struct packed {
        logic        cs_s0;
        logic        cs_s1;
        logic        sclk_s0;
        logic        sclk_s1;
        logic        sclk_prev;
        logic        mosi_s0;
        logic        mosi_s1;
        swa_state_e  fsm;
        logic [3:0]  cnt;
        logic [7:0]  cmd;
        logic [15:0] addr;
        logic [15:0] in_sr;
        logic [15:0] out_sr;
        logic        miso;
    } swa_slave_s;

    localparam swa_slave_s SLAVE_RST = '{
        cs_s0: 1'b1, cs_s1: 1'b1, sclk_s0: 1'b0, sclk_s1: 1'b0, sclk_prev: 1'b0,
        mosi_s0: 1'b0, mosi_s1: 1'b0, fsm: ST_IDLE, cnt: 4'h0, cmd: 8'h00,
        addr: ADDR_RST, in_sr: WORD_RST, out_sr: WORD_RST, miso: 1'b0};

endpackage : swa_pkg

// >>> design/swa_mem_if.sv
//
// Purpose: carrier between the serial slave and its word store
// Assumes: one clock, read data registered in the store
// Notes:   store reads addr every cycle; we writes wdata at addr
//
`timescale 1ns/10ps
interface swa_mem_if;
    import swa_pkg::*;
    logic                we;
    logic [MEM_AW-1:0]   addr;
    logic [WORD_W-1:0]   wdata;
    logic [WORD_W-1:0]   rdata;

    modport master (output we, output addr, output wdata, input rdata);
    modport store  (input we, input addr, input wdata, output rdata);
endinterface : swa_mem_if

// >>> design/swa_mem.sv
//
// Purpose: word store reached by the serial slave
// Assumes: synchronous write, registered read of addr every cycle
// Notes:   read data show the word one cycle after addr settles
//
`timescale 1ns/10ps
module swa_mem (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    swa_mem_if.store    mem
);
    import swa_pkg::*;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][WORD_W-1:0] word;
        logic [WORD_W-1:0]                rdata;
    } swa_mem_s;

    swa_mem_s q;
    swa_mem_s next_q;

    // ************************************************************
    // write and registered read
    // ************************************************************
    always_comb begin
        next_q = q;
        if (mem.we) begin
            next_q.word[mem.addr] = mem.wdata;
        end
        next_q.rdata = q.word[mem.addr];
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign mem.rdata = q.rdata;
endmodule // swa_mem

// >>> testbench/swa_link_master.sv
//
// Purpose: serial master model for the word access link
// Assumes: link clock 320 ns, high 200 ns, low 120 ns
// Notes:   every reply bit is taken at a falling edge into rx
//
`timescale 1ns/10ps
module swa_link_master
    import swa_pkg::*;
(
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi,
    input  wire logic i_miso
);
    logic [127:0] rx;

    // ************************************************************
    // one framed transfer, fields msb first
    // ************************************************************
    task automatic frame(input logic [7:0] cmd, input logic [15:0] addr,
                         input logic [63:0] wd, input int n);
        logic [87:0] tx;
        int          e;
        tx = {cmd, addr, wd};
        e = (cmd == CMD_READ) ? 40 + 16 * n : 24 + 16 * n;
        o_cs_n = 1'h0;
        #160;
        for (int k = 0; k < e; k++) begin
            o_mosi = (k < 88) ? tx[87 - k] : 1'h0;
            #120 o_sclk = 1'h1;
            #200 rx = {rx[126:0], i_miso};
            o_sclk = 1'h0;
        end
        #120 o_cs_n = 1'h1;
        o_mosi = ~o_mosi;  // no stale bit once released
        repeat (2) begin
            #160 o_sclk = 1'h1;
            #160 o_sclk = 1'h0;
        end
    endtask

    // idle levels at time zero
    initial begin
        o_cs_n = 1'h1;
        o_sclk = 1'h0;
        o_mosi = 1'h0;
        rx = '0;
    end
endmodule // swa_link_master

// >>> testbench/swa_slave_tb_top.sv
//
// Purpose: self-checking bench for the serial word access slave
// Assumes: link master model drives the link pins
// Notes:   store contents seen only through reads
//
`timescale 1ns/10ps
module swa_slave_tb_top;
    import swa_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
        logic        run;
    } swa_row_s;
    localparam int LIMIT = 20000;
    logic     sys_clk, rst_b, cpu_run, cs_n, sclk, mosi, miso;
    int       fail_count = 0;
    int       compares = 0;
    int       cycles = 0;
    swa_row_s rows [3] = '{'{16'h0000, 16'hA55A, 1'h1}, '{16'h12FF, 16'h8001, 1'h0},
                           '{16'hFF80, 16'h7FFE, 1'h1}};

    swa_slave dut (.I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_CPU_RUN(cpu_run), .I_CHIP_SELECT_N(cs_n),
                   .I_SPI_SCLK(sclk), .I_SPI_MOSI(mosi), .O_SPI_MISO(miso));
    swa_link_master lnk (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso));

    // ************************************************************
    // clock, hang guard
    // ************************************************************
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end

    // ************************************************************
    // compare and helper tasks
    // ************************************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    // read n words and compare check word and data
    task automatic rdchk(input logic [15:0] a, input logic [63:0] exp, input int n);
        lnk.frame(CMD_READ, a, 64'h0, n);
        chk16(lnk.rx[16 * n + 15 -: 16], {CMD_READ, a[15:8]}, "check word");
        for (int i = 0; i < n; i++) begin
            chk16(lnk.rx[16 * n - 1 - 16 * i -: 16], exp[63 - 16 * i -: 16], "read word");
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rst_b = 1'h0;
        cpu_run = 1'h1;
        repeat (10) @(negedge sys_clk);
        chk1(miso, 1'h0, "reset level");
        repeat (10) @(negedge sys_clk);
        rst_b = 1'h1;
        repeat (6) @(negedge sys_clk);
        chk1(miso, 1'h0, "idle running");
        $display("test reset done");
        // single write then read back, processor running or halted
        foreach (rows[r]) begin
            @(negedge sys_clk);
            cpu_run = rows[r].run;
            repeat (3) @(negedge sys_clk);
            chk1(miso, ~rows[r].run, "idle level");
            lnk.frame(CMD_WRITE, rows[r].addr, {rows[r].data, 48'h0}, 1);
            rdchk(rows[r].addr, {rows[r].data, 48'h0}, 1);
            $display("test row %0d done", r);
        end
        // block write across the top of the store, then block read
        lnk.frame(CMD_WRITE, 16'h00FE, 64'h1111_2222_3333_0000, 3);
        rdchk(16'h00FE, 64'h1111_2222_3333_0000, 3);
        $display("test block done");
        // unknown command leaves the store alone
        lnk.frame(8'h05, 16'h0010, 64'hDEAD_0000_0000_0000, 1);
        chk16(lnk.rx[15:0], 16'h0000, "unknown reply");
        rdchk(16'h0010, 64'h0, 1);
        $display("test unknown done");
        // reset in mid-run: store cleared, halted idle level afterwards
        @(negedge sys_clk);
        cpu_run = 1'h0;
        rst_b = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk1(miso, 1'h0, "mid reset level");
        rst_b = 1'h1;
        repeat (6) @(negedge sys_clk);
        chk1(miso, 1'h1, "idle halted");
        rdchk(16'h00FF, 64'h0, 1);
        $display("test mid reset done");
        stop_test();
    end
endmodule // swa_slave_tb_top
